// [core/phy_strap_map.vh]
// Constants for the receive-pin strap and MII receive block.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef PHY_STRAP_MAP_VH
`define PHY_STRAP_MAP_VH

// Register byte offsets
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04

// Control register fields
`define CTRL_MDIX_BIT 0
`define CTRL_MDIO_DRIVE_BIT 1
`define CTRL_MDIO_VALUE_BIT 2
`define CTRL_RESET_VAL 3'h0

// Status register fields
`define STAT_EMI_BIT 0
`define STAT_CFG2_BIT 1
`define STAT_ADDR0_BIT 2
`define STAT_MDIO_BIT 3
`define STAT_MDIX_BIT 4

// Clock rates and the receive clock divide ratio
`define MCLK_FREQ_HZ 100000000
`define RXCLK_FREQ_HZ 25000000
`define RXCLK_DIV (`MCLK_FREQ_HZ / `RXCLK_FREQ_HZ)

// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// [core/phy_strap_rx_pins.v]
// Shared MII receive pins with reset-time strap capture, pair direction
// control and management line timing, behind an AHB-Lite register slave.
// Assumes one 100 MHz clock, synchronous reset, and external pull resistors
// that the pull-enable output switches on during reset.
`timescale 1ns/100ps
`include "phy_strap_map.vh"
module phy_strap_rx_pins (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Receive stream from the PHY datapath
    input wire [3:0] rxNibbleIn,
    input wire rxValidIn,
    input wire rxErrIn,
    output wire rxTake,
    // MII receive pins towards the MAC
    output wire rxClkOut,
    output wire [3:0] rxDataOut,
    output wire rxDataOeN,
    input wire rxData3In,
    output wire rxDvOut,
    output wire rxDvOeN,
    input wire rxDvIn,
    output wire rxErrOut,
    output wire rxErrOeN,
    input wire rxErrPinIn,
    output wire strapPullEn,
    // Captured straps
    output wire emiFilterStrap,
    output wire configStrapBit2,
    output wire phyAddressBit0,
    // Cable pair direction
    output wire pairATransmit,
    output wire pairBTransmit,
    // Management interface
    input wire mdcIn,
    input wire mdioIn,
    output wire mdioOut,
    output wire mdioOeN
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [4:0] syncLevel; // {mdio, mdc, rxd3, rxdv, rxer}
    pin_sync #(
        .WIDTH(5)
    ) uSync (
        .mclk(mclk),
        .rst(1'b0),
        .pinIn({mdioIn, mdcIn, rxData3In, rxDvIn, rxErrPinIn}),
        .levelOut(syncLevel)
    );
    // Synchroniser is never reset so the pulled levels are tracked during reset

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture
    reg emiStrap_reg; // Filter select
    reg cfg2Strap_reg; // Config bit 2
    reg phyAd0Strap_reg; // Address bit 0
    reg pullEn_reg; // Pull resistors on
    // Track the pins through reset; the value at the release edge is kept
    always @(posedge mclk) begin
        if (rst) begin
            emiStrap_reg <= syncLevel[0];
            cfg2Strap_reg <= syncLevel[1];
            phyAd0Strap_reg <= syncLevel[2];
            pullEn_reg <= 1'b1;
        end else begin
            pullEn_reg <= 1'b0;
        end
    end
    // Limitation: the pin level must be settled at least five cycles before release

    ////////////////////////////////////////////////////////////////////////////
    // Receive clock divider
    reg [1:0] divCnt_reg; // Phase inside one receive clock period
    reg rxClk_reg; // Receive clock to the MAC
    always @(posedge mclk) begin
        if (rst) begin
            divCnt_reg <= 2'h0;
            rxClk_reg <= 1'h0;
        end else begin
            divCnt_reg <= divCnt_reg + 2'h1;
            // Low half then high half of each period
            if (divCnt_reg == 2'h3) begin
                rxClk_reg <= 1'b0;
            end else if (divCnt_reg == 2'h1) begin
                rxClk_reg <= 1'b1;
            end
        end
    end
    wire nibbleTick = (divCnt_reg == 2'h3); // Falling edge of rxClk next

    ////////////////////////////////////////////////////////////////////////////
    // Receive data path
    reg [3:0] rxData_reg;
    reg rxDv_reg;
    reg rxErr_reg;
    reg rxOeN_reg; // High while the pins are strap inputs
    reg rxTake_reg; // One-cycle pulse per nibble taken
    always @(posedge mclk) begin
        if (rst) begin
            rxData_reg <= 4'h0;
            rxDv_reg <= 1'h0;
            rxErr_reg <= 1'h0;
            rxOeN_reg <= 1'b1;
            rxTake_reg <= 1'h0;
        end else begin
            rxOeN_reg <= 1'b0;
            rxTake_reg <= nibbleTick;
            if (nibbleTick) begin
                rxData_reg <= rxValidIn ? rxNibbleIn : 4'h0;
                rxDv_reg <= rxValidIn;
                rxErr_reg <= rxValidIn & rxErrIn;
            end
        end
    end
    // Data moves half a period before the MAC's sampling edge, giving full setup

    ////////////////////////////////////////////////////////////////////////////
    // Management line timing
    reg mdcPrev_reg; // Last accepted management clock level
    reg mdioSample_reg; // Data bit taken at the clock's rising edge
    reg mdioOut_reg;
    reg mdioOeN_reg;
    reg [2:0] ctrl_reg; // Control register
    always @(posedge mclk) begin
        if (rst) begin
            mdcPrev_reg <= 1'h0;
            mdioSample_reg <= 1'h0;
            mdioOut_reg <= 1'h1;
            mdioOeN_reg <= 1'h1;
        end else begin
            mdcPrev_reg <= syncLevel[3];
            if (syncLevel[3] && !mdcPrev_reg) begin
                mdioSample_reg <= syncLevel[4];
            end
            if (!syncLevel[3] && mdcPrev_reg) begin
                mdioOut_reg <= ctrl_reg[`CTRL_MDIO_VALUE_BIT];
                // Open-drain like: only a low is driven
                mdioOeN_reg <= ~(ctrl_reg[`CTRL_MDIO_DRIVE_BIT]
                                 & ~ctrl_reg[`CTRL_MDIO_VALUE_BIT]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pair direction
    reg pairATx_reg;
    reg pairBTx_reg;
    always @(posedge mclk) begin
        if (rst) begin
            pairATx_reg <= 1'h1;
            pairBTx_reg <= 1'h0;
        end else begin
            pairATx_reg <= ~ctrl_reg[`CTRL_MDIX_BIT];
            pairBTx_reg <= ctrl_reg[`CTRL_MDIX_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    reg wrPend_reg; // Write data phase pending
    reg [7:0] wrAddr_reg;
    reg [31:0] rdata_reg;
    wire accept = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
    reg [31:0] rdNext; // Read data for the address in the address phase
    // Decode read data; unmapped offsets read as zero
    always @* begin
        rdNext = 32'h0;
        case (haddr)
            `REG_CTRL_OFS: begin
                rdNext[2:0] = ctrl_reg;
            end
            `REG_STATUS_OFS: begin
                rdNext[`STAT_EMI_BIT] = emiStrap_reg;
                rdNext[`STAT_CFG2_BIT] = cfg2Strap_reg;
                rdNext[`STAT_ADDR0_BIT] = phyAd0Strap_reg;
                rdNext[`STAT_MDIO_BIT] = mdioSample_reg;
                rdNext[`STAT_MDIX_BIT] = pairBTx_reg;
            end
            default: begin
                rdNext = 32'h0;
            end
        endcase
    end
    // Address phase capture and write data phase
    always @(posedge mclk) begin
        if (rst) begin
            wrPend_reg <= 1'h0;
            wrAddr_reg <= 8'h0;
            rdata_reg <= 32'h0;
            ctrl_reg <= `CTRL_RESET_VAL;
        end else begin
            if (wrPend_reg && wrAddr_reg == `REG_CTRL_OFS) begin
                ctrl_reg <= hwdata[2:0];
            end
            // Status is read-only; writes elsewhere are ignored
            wrPend_reg <= accept && hwrite;
            if (accept) begin
                wrAddr_reg <= haddr;
                rdata_reg <= hwrite ? 32'h0 : rdNext;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rxTake = rxTake_reg;
    assign rxClkOut = rxClk_reg;
    assign rxDataOut = rxData_reg;
    assign rxDataOeN = rxOeN_reg;
    assign rxDvOut = rxDv_reg;
    assign rxDvOeN = rxOeN_reg;
    assign rxErrOut = rxErr_reg;
    assign rxErrOeN = rxOeN_reg;
    assign strapPullEn = pullEn_reg;
    assign emiFilterStrap = emiStrap_reg;
    assign configStrapBit2 = cfg2Strap_reg;
    assign phyAddressBit0 = phyAd0Strap_reg;
    assign pairATransmit = pairATx_reg;
    assign pairBTransmit = pairBTx_reg;
    assign mdioOut = mdioOut_reg;
    assign mdioOeN = mdioOeN_reg;

endmodule

// [core/pin_sync.v]
// Three-stage input synchroniser for pins from outside the mclk domain.
// Assumes a synchronous active-high reset; output moves once stages 2 and 3 agree.
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Raw pins and filtered levels
    input wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] levelOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gSync
            reg s1_reg; // Only read by s2_reg
            reg s2_reg;
            reg s3_reg;
            reg level_reg; // Accepted level
            ////////////////////////////////////////////////////////////////////
            // Shift chain and agreement filter
            always @(posedge mclk) begin
                if (rst) begin
                    s1_reg <= 1'h0;
                    s2_reg <= 1'h0;
                    s3_reg <= 1'h0;
                    level_reg <= 1'h0;
                end else begin
                    s1_reg <= pinIn[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // Accept only a level seen twice, so a metastable sample is dropped
                    if (s2_reg == s3_reg) begin
                        level_reg <= s3_reg;
                    end
                end
            end
            assign levelOut[i] = level_reg;
        end
    endgenerate

endmodule

// [tb/mii_mac_model.sv]
// Receiving MAC with the board pull resistors on the strap pins.
// Assumes the bench reads the captured nibbles from its queue.
`timescale 1ns/100ps
module mii_mac_model (
    // Pins from the device
    input wire rxClkOut,
    input wire [3:0] rxDataOut,
    input wire rxDvOut,
    input wire rxErrOut,
    input wire rxDataOeN,
    input wire rxDvOeN,
    input wire rxErrOeN,
    // Board pull levels
    input wire [2:0] pullLvl,
    // Resolved pin levels
    output wire d3Pin,
    output wire dvPin,
    output wire erPin
);
    // Nibbles taken so far, with the error line on top
    logic [4:0] got[$];
    // Released lines rest at the pull level
    assign d3Pin = rxDataOeN ? pullLvl[2] : rxDataOut[3];
    assign dvPin = rxDvOeN ? pullLvl[1] : rxDvOut;
    assign erPin = rxErrOeN ? pullLvl[0] : rxErrOut;
    always @(posedge rxClkOut) begin
        if (rxDvOut === 1'b1) begin
            got.push_back({rxErrOut, rxDataOut});
        end
    end
endmodule

// [tb/phy_strap_rx_pins_chk.sv]
// Checker for the strap and receive pin block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/100ps
module phy_strap_rx_pins_chk (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Receive pins
    input wire rxClkOut,
    input wire [3:0] rxDataOut,
    input wire rxDvOut,
    input wire rxDataOeN,
    input wire strapPullEn,
    // Strap pins and captured values
    input wire rxData3In,
    input wire rxDvIn,
    input wire rxErrPinIn,
    input wire emiFilterStrap,
    input wire configStrapBit2,
    input wire phyAddressBit0,
    // Pairs and management
    input wire pairATransmit,
    input wire pairBTransmit,
    input wire mdcIn,
    input wire mdioOeN
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // Clock high for two cycles, then low
    sequence s_highTwo;
        rxClkOut ##1 rxClkOut ##1 !rxClkOut;
    endsequence
    property p_clkShape;
        $rose(rxClkOut) |-> s_highTwo;
    endproperty
    a_clkShape: assert property (p_clkShape) else $error("rx clock shape wrong");
    property p_dataStep;
        $changed(rxDataOut) |-> $fell(rxClkOut);
    endproperty
    a_dataStep: assert property (p_dataStep) else $error("data moved off clock fall");
    property p_idleZero;
        !rxDvOut |-> rxDataOut == 4'h0;
    endproperty
    a_idleZero: assert property (p_idleZero) else $error("data not quiet when invalid");
    // Pins held as pulled inputs up to the release edge
    property p_pulledInReset;
        $fell(rst) |-> rxDataOeN && strapPullEn;
    endproperty
    a_pulledInReset: assert property (p_pulledInReset) else $error("pins not pulled in reset");
    property p_driveAfter;
        !rst |=> !rxDataOeN && !strapPullEn;
    endproperty
    a_driveAfter: assert property (p_driveAfter) else $error("pins not driven after reset");
    // Pins stay steady through a long reset in the bench
    property p_capture;
        $fell(rst) |-> emiFilterStrap == $past(rxErrPinIn, 5) &&
            configStrapBit2 == $past(rxDvIn, 5) && phyAddressBit0 == $past(rxData3In, 5);
    endproperty
    a_capture: assert property (p_capture) else $error("strap capture wrong");
    property p_hold;
        !rst |=> $stable({emiFilterStrap, configStrapBit2, phyAddressBit0});
    endproperty
    a_hold: assert property (p_hold) else $error("strap moved after reset");
    property p_pairs;
        pairATransmit != pairBTransmit;
    endproperty
    a_pairs: assert property (p_pairs) else $error("pair roles not exclusive");
    property p_mdioOnFall;
        $changed(mdioOeN) |-> !$past(mdcIn, 2);
    endproperty
    a_mdioOnFall: assert property (p_mdioOnFall) else $error("mdio drive moved off mdc low");
endmodule
bind phy_strap_rx_pins phy_strap_rx_pins_chk u_chk (.mclk(mclk), .rst(rst),
    .rxClkOut(rxClkOut), .rxDataOut(rxDataOut), .rxDvOut(rxDvOut), .rxDataOeN(rxDataOeN),
    .strapPullEn(strapPullEn), .rxData3In(rxData3In), .rxDvIn(rxDvIn),
    .rxErrPinIn(rxErrPinIn), .emiFilterStrap(emiFilterStrap),
    .configStrapBit2(configStrapBit2), .phyAddressBit0(phyAddressBit0),
    .pairATransmit(pairATransmit), .pairBTransmit(pairBTransmit), .mdcIn(mdcIn),
    .mdioOeN(mdioOeN));

// [tb/phy_strap_rx_pins_tb_top.sv]
// Self-checking bench for the strap and receive pin block.
// Assumes the MAC model and the bound checker sit beside the block.
`timescale 1ns/100ps
`include "phy_strap_map.vh"
module phy_strap_rx_pins_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] rxNibbleIn = 4'h0;
    logic rxValidIn = 1'b0;
    logic rxErrIn = 1'b0;
    logic mdcIn = 1'b0;
    logic mdioIn = 1'b1;
    logic [2:0] pullLvl = 3'h5;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hresp;
    wire [3:0] rxDataOut;
    wire hreadyout, rxTake, rxClkOut, rxDataOeN, rxDvOut, rxDvOeN, rxErrOut, rxErrOeN;
    wire d3Pin, dvPin, erPin, strapPullEn, emiFilterStrap, configStrapBit2, phyAddressBit0;
    wire pairATransmit, pairBTransmit, mdioOut, mdioOeN;
    int failCount = 0;
    int nTests = 0;
    // reference rate supplied by the bench
    always #5 mclk = ~mclk;
    phy_strap_rx_pins u_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxNibbleIn, .rxValidIn,
        .rxErrIn, .rxTake, .rxClkOut, .rxDataOut, .rxDataOeN, .rxData3In(d3Pin),
        .rxDvOut, .rxDvOeN, .rxDvIn(dvPin), .rxErrOut, .rxErrOeN, .rxErrPinIn(erPin),
        .strapPullEn, .emiFilterStrap, .configStrapBit2, .phyAddressBit0, .pairATransmit,
        .pairBTransmit, .mdcIn, .mdioIn, .mdioOut, .mdioOeN);
    mii_mac_model u_mac (.rxClkOut, .rxDataOut, .rxDvOut, .rxErrOut, .rxDataOeN, .rxDvOeN,
        .rxErrOeN, .pullLvl, .d3Pin, .dvPin, .erPin);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single word transfer; waits on hready, no fixed latency assumed
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        // The slave must always answer OKAY
        chk(hresp, 1'b0);
    endtask
    // Reset longer than four cycles so the pin synchronisers fill
    task automatic t_straps(input logic [2:0] lv);
        rst <= 1'b1;
        pullLvl <= lv;
        repeat (8) @(posedge mclk);
        chk({rxDataOeN, rxDvOeN, rxErrOeN, strapPullEn}, 4'hF);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({rxDataOeN, rxDvOeN, rxErrOeN, strapPullEn}, 4'h0);
        pullLvl <= ~lv;
        repeat (6) @(posedge mclk);
        chk({phyAddressBit0, configStrapBit2, emiFilterStrap}, lv);
        ahb(1'b0, `REG_STATUS_OFS, 32'h0);
        chk(rd[2:0], lv);
    endtask
    // Each nibble goes on just after a take pulse, so it stands a whole period
    // before the next take; the last nibble carries a receive error
    task automatic t_rx;
        logic [3:0] pat [4] = '{4'h5, 4'hA, 4'h3, 4'hC};
        int k;
        u_mac.got.delete();
        for (int i = 0; i <= 4; i++) begin
            k = 0;
            do begin @(posedge mclk); k++; end while (rxTake !== 1'b1 && k < 20);
            // A missing take pulse counts as a mismatch
            if (k >= 20) begin
                failCount++;
            end
            if (i < 4) begin
                rxNibbleIn <= pat[i];
                rxValidIn <= 1'b1;
                rxErrIn <= (i == 3);
            end
        end
        rxValidIn <= 1'b0;
        repeat (12) @(posedge mclk);
        chk(rxErrOut, 1'b0);
        rxErrIn <= 1'b0;
        chk(32'(u_mac.got.size()), 32'd4);
        foreach (u_mac.got[i]) chk(u_mac.got[i], {(i == 3), pat[i]});
    endtask
    task automatic t_pairs(input logic [31:0] mode);
        ahb(1'b1, `REG_CTRL_OFS, mode);
        repeat (2) @(posedge mclk);
        chk({pairATransmit, pairBTransmit}, {1'b0, ~mode[0], mode[0]});
        ahb(1'b0, `REG_STATUS_OFS, 32'h0);
        chk(rd[`STAT_MDIX_BIT], mode[0]);
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
    endtask
    // One management clock pulse, then check drive and sampled data
    task automatic t_mdio(input logic [31:0] mode, input logic din);
        ahb(1'b1, `REG_CTRL_OFS, mode);
        mdioIn <= din;
        mdcIn <= 1'b1;
        repeat (8) @(posedge mclk);
        mdcIn <= 1'b0;
        repeat (8) @(posedge mclk);
        chk({mdioOeN, mdioOut}, {~(mode[1] & ~mode[2]), mode[2]});
        ahb(1'b0, `REG_STATUS_OFS, 32'h0);
        chk(rd[`STAT_MDIO_BIT], din);
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard, far above the hundred or so cycles the run needs
    initial begin
        #100000;
        failCount++;
        conclude();
    end
    initial begin
        @(posedge mclk);
        t_straps(3'h5);
        t_straps(3'h2);
        t_rx();
        t_pairs(32'h1);
        t_pairs(32'h0);
        t_mdio(32'h2, 1'b1);
        t_mdio(32'h4, 1'b0);
        conclude();
    end
endmodule
